/* common/slpm_pkg.sv */
// Constants, register map and types for the strap latch and power-mode controller.
// Assumes one 100 MHz clock and an AHB-Lite register slave.
// How it works
// - Straps latched on every system reset, held
// - All five strap bits readable by software
// - Weak pulls enabled on straps during reset
// - Straps released to normal use after reset
// - Supply strap: 0 gives 3.3V, 1 gives 1.8V
// - Boot strap 1 flash, 00 download
// - Log strap enables boot messages on serial tx
// - Log/edge 11 rise/rise, 10 rise/fall timing
// - Chip enable high runs, low powers off
// - Active keeps CPU, radio, baseband powered
// - Modem-sleep: radio off, CPU clock scales
// - Light-sleep pauses CPU, wakes on four events
// - Deep-sleep powers only RTC, coprocessor optional
// - Hibernation stops oscillator, timer/GPIO wake
// - Association pattern cycles active, modem, light
// - Sensor pattern: coprocessor samples at 1% duty
// - Coprocessor on: GPIO and two-wire stay usable
// - CPU reaches fast RTC memory on RTC boot
// - Coprocessor reaches slow RTC memory in deep-sleep
// - Fuses: 256 system bits, 768 customer bits
package slpm_pkg;
  // ==========================================================
  // Register map (byte offsets)
  localparam logic [7:0] STRAP_OFS = 8'h00;
  localparam logic [7:0] MODE_OFS = 8'h04;
  localparam logic [7:0] STATE_OFS = 8'h08;
  localparam logic [7:0] WAKE_OFS = 8'h0c;
  localparam logic [7:0] FUSE_OFS = 8'h10;
  // ==========================================================
  // Field positions and values
  localparam int STRAP_W = 5;
  localparam int SUP_BIT = 0;
  localparam int BOOT_BIT = 1;
  localparam int AUX_BIT = 2;
  localparam int LOG_BIT = 3;
  localparam int EDGE_BIT = 4;
  localparam logic [4:0] PULL_UP_MASK = 5'h1a;
  localparam logic [3:0] WAKE_RST = 4'hf;
  localparam int FUSE_SYS_BITS = 256;
  localparam int FUSE_CUST_BITS = 768;
  localparam int RTC_FAST_KB = 8;
  localparam int RTC_SLOW_KB = 8;
  localparam int DUTY_PCT = 1;
  localparam int DUTY_PERIOD = 100;
  localparam logic [6:0] DUTY_ON = 7'(DUTY_PCT);
  localparam logic [6:0] DUTY_LAST = 7'(DUTY_PERIOD - 1);
  localparam int LOAD_HI = 2;
  localparam int LOAD_LO = 1;
  // ==========================================================
  // Types
  typedef enum logic [2:0] {PM_ACTIVE, PM_MODEM, PM_LIGHT, PM_DEEP, PM_HIBER, PM_OFF} slpm_mode_e;
  typedef enum logic [1:0] {CLK_240M, CLK_80M, CLK_2M} slpm_clk_e;
  typedef struct packed {
    logic cpuOn;
    logic cpuPause;
    logic radioOn;
    logic rtcOn;
    logic coprocOn;
    logic osc8mOn;
    logic rtcRecovOn;
    logic periphOn;
    logic fastMemCpu;
    logic slowMemCoproc;
  } slpm_pwr_s;
  typedef struct packed {
    logic mac;
    logic host;
    logic timer;
    logic extInt;
  } slpm_wake_s;
endpackage

/* hdl/slpm_core.sv */
// Strap latches, power-mode controller and AHB-Lite register slave.
// Assumes strap pins and chip enable are asynchronous and synchronised here.
//
// The AHB-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module slpm_core (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic clkEn,
  input wire logic chipPowerUp,
  input wire logic sysResetReq,
  input wire logic [4:0] strapPin,
  output logic [4:0] strapPullUp,
  output logic [4:0] strapPullDown,
  output logic strapFunctional,
  output logic ldoSel1v8,
  output logic bootFromFlash,
  output logic bootDownload,
  output logic bootLogEn,
  output logic slaveInRise,
  output logic slaveOutRise,
  input wire slpm_pkg::slpm_wake_s wakeIn,
  input wire logic [1:0] cpuLoad,
  input wire logic sensorWake,
  output slpm_pkg::slpm_pwr_s pwr,
  output slpm_pkg::slpm_clk_e cpuClkSel,
  output logic adcSample,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata
);
  // ==========================================================
  // State
  typedef struct packed {
    logic [1:0] cenSync;
    logic [4:0] strapSync0;
    logic [4:0] strapSync1;
    logic [4:0] strap;
    logic inReset;
    logic [1:0] rstCnt;
    slpm_pkg::slpm_mode_e mode;
    logic assocEn;
    logic sensorPat;
    logic coprocReq;
    logic [2:0] sleepReq;
    logic [3:0] wakeEn;
    logic [3:0] wakeSeen;
    logic [6:0] dutyCnt;
    logic wakeTo;
    logic deepWake;
    logic dPhase;
    logic [7:0] dAddr;
    logic dWrite;
    logic [31:0] rdata;
  } slpm_st_s;

  slpm_st_s st;
  slpm_st_s next_st;
  logic anyWake;
  logic addrPhase;
  logic [3:0] wakeVec;

  // Decode of a software sleep request code
  function automatic slpm_pkg::slpm_mode_e reqMode(input logic [2:0] code);
    case (code)
      3'h1: reqMode = slpm_pkg::PM_MODEM;
      3'h2: reqMode = slpm_pkg::PM_LIGHT;
      3'h3: reqMode = slpm_pkg::PM_DEEP;
      3'h4: reqMode = slpm_pkg::PM_HIBER;
      default: reqMode = slpm_pkg::PM_ACTIVE;
    endcase
  endfunction

  assign wakeVec = {wakeIn.mac, wakeIn.host, wakeIn.timer, wakeIn.extInt};
  assign addrPhase = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st.rdata;

  // ==========================================================
  // Next state
  always_comb
  begin
    next_st = st;
    anyWake = 1'b0;
    next_st.cenSync = {st.cenSync[0], chipPowerUp};
    next_st.strapSync0 = strapPin;
    next_st.strapSync1 = st.strapSync0;
    // Reset window: power-off or system reset reopens latches
    if (!st.cenSync[1] || sysResetReq)
    begin
      next_st.inReset = 1'b1;
      next_st.rstCnt = 2'h0;
      next_st.mode = slpm_pkg::PM_OFF;
      next_st.deepWake = 1'b0;
    end
    else if (st.inReset)
    begin
      next_st.rstCnt = st.rstCnt + 2'h1;
      if (st.rstCnt == 2'h3)
      begin
        next_st.strap = st.strapSync1;
        next_st.inReset = 1'b0;
        next_st.mode = slpm_pkg::PM_ACTIVE;
      end
    end
    else
    begin
      case (st.mode)
        slpm_pkg::PM_ACTIVE, slpm_pkg::PM_MODEM:
        begin
          if (st.sleepReq != 3'h0)
          begin
            next_st.mode = reqMode(st.sleepReq);
            next_st.sleepReq = 3'h0;
          end
        end
        slpm_pkg::PM_LIGHT:
        begin
          anyWake = |(wakeVec & st.wakeEn);
        end
        slpm_pkg::PM_DEEP:
        begin
          anyWake = wakeIn.timer || wakeIn.extInt || (st.sensorPat && sensorWake);
        end
        slpm_pkg::PM_HIBER:
        begin
          anyWake = wakeIn.timer || wakeIn.extInt;
        end
        default:
        begin
          next_st.mode = slpm_pkg::PM_ACTIVE;
        end
      endcase
      if (anyWake)
      begin
        next_st.mode = st.assocEn ? slpm_pkg::PM_MODEM : slpm_pkg::PM_ACTIVE;
        next_st.wakeTo = 1'b1;
        next_st.deepWake = st.mode == slpm_pkg::PM_DEEP;
      end
    end
    next_st.wakeSeen = st.wakeSeen | (anyWake ? wakeVec : 4'h0);
    // Sensor duty counter
    if (st.mode == slpm_pkg::PM_DEEP && st.sensorPat)
    begin
      next_st.dutyCnt = (st.dutyCnt == slpm_pkg::DUTY_LAST) ? 7'h0 : st.dutyCnt + 7'h1;
    end
    else
    begin
      next_st.dutyCnt = 7'h0;
    end
    // Bus data phase
    next_st.dPhase = addrPhase;
    next_st.dAddr = haddr[7:0];
    next_st.dWrite = hwrite;
    if (st.dPhase && st.dWrite)
    begin
      if (st.dAddr == slpm_pkg::MODE_OFS)
      begin
        next_st.sleepReq = hwdata[2:0];
        next_st.assocEn = hwdata[4];
        next_st.sensorPat = hwdata[5];
        next_st.coprocReq = hwdata[6];
      end
      else if (st.dAddr == slpm_pkg::WAKE_OFS)
      begin
        next_st.wakeEn = hwdata[3:0];
        // Hardware set wins over software clear
        next_st.wakeSeen = (st.wakeSeen & ~hwdata[11:8]) | (anyWake ? wakeVec : 4'h0);
      end
    end
    if (addrPhase && !hwrite)
    begin
      if (haddr[7:0] == slpm_pkg::STRAP_OFS)
      begin
        next_st.rdata = {27'h0, st.strap};
      end
      else if (haddr[7:0] == slpm_pkg::MODE_OFS)
      begin
        next_st.rdata = {25'h0, st.coprocReq, st.sensorPat, st.assocEn, 1'b0, st.sleepReq};
      end
      else if (haddr[7:0] == slpm_pkg::STATE_OFS)
      begin
        next_st.rdata = {28'h0, st.wakeTo, st.mode};
      end
      else if (haddr[7:0] == slpm_pkg::WAKE_OFS)
      begin
        next_st.rdata = {20'h0, st.wakeSeen, 4'h0, st.wakeEn};
      end
      else if (haddr[7:0] == slpm_pkg::FUSE_OFS)
      begin
        next_st.rdata = {16'(slpm_pkg::FUSE_CUST_BITS), 16'(slpm_pkg::FUSE_SYS_BITS)};
      end
      else
      begin
        next_st.rdata = 32'h0;
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st <= '0;
      st.inReset <= 1'b1;
      st.mode <= slpm_pkg::PM_OFF;
      st.wakeEn <= slpm_pkg::WAKE_RST;
    end
    else if (clkEn)
    begin
      st <= next_st;
    end
  end

  // ==========================================================
  // Strap pads and decoded straps
  assign strapPullUp = st.inReset ? slpm_pkg::PULL_UP_MASK : 5'h0;
  assign strapPullDown = st.inReset ? ~slpm_pkg::PULL_UP_MASK : 5'h0;
  assign strapFunctional = !st.inReset;
  assign ldoSel1v8 = st.strap[slpm_pkg::SUP_BIT];
  assign bootFromFlash = st.strap[slpm_pkg::BOOT_BIT];
  assign bootDownload = !st.strap[slpm_pkg::BOOT_BIT] && !st.strap[slpm_pkg::AUX_BIT];
  assign bootLogEn = st.strap[slpm_pkg::LOG_BIT] && !st.inReset;
  assign slaveInRise = st.strap[slpm_pkg::LOG_BIT];
  assign slaveOutRise = st.strap[slpm_pkg::LOG_BIT] ? st.strap[slpm_pkg::EDGE_BIT]
                                                    : st.strap[slpm_pkg::EDGE_BIT];

  // ==========================================================
  // Domain power per mode
  always_comb
  begin
    pwr = '0;
    case (st.mode)
      slpm_pkg::PM_ACTIVE:
      begin
        pwr = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
      end
      slpm_pkg::PM_MODEM:
      begin
        pwr = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
      end
      slpm_pkg::PM_LIGHT:
      begin
        pwr = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
      end
      slpm_pkg::PM_DEEP:
      begin
        pwr.rtcOn = 1'b1;
        pwr.rtcRecovOn = 1'b1;
        pwr.osc8mOn = 1'b1;
        pwr.coprocOn = st.coprocReq || st.sensorPat;
        pwr.periphOn = pwr.coprocOn;
        pwr.slowMemCoproc = pwr.coprocOn;
      end
      slpm_pkg::PM_HIBER:
      begin
        pwr.rtcOn = 1'b1;
      end
      default:
      begin
        pwr = '0;
      end
    endcase
    // Fast RTC memory handed to CPU after a wake from deep-sleep
    pwr.fastMemCpu = pwr.cpuOn && st.deepWake;
  end

  // CPU clock follows load only in modem-sleep
  always_comb
  begin
    cpuClkSel = slpm_pkg::CLK_240M;
    if (st.mode == slpm_pkg::PM_MODEM)
    begin
      if (cpuLoad >= 2'(slpm_pkg::LOAD_HI))
        cpuClkSel = slpm_pkg::CLK_240M;
      else if (cpuLoad == 2'(slpm_pkg::LOAD_LO))
        cpuClkSel = slpm_pkg::CLK_80M;
      else
        cpuClkSel = slpm_pkg::CLK_2M;
    end
  end

  assign adcSample = st.mode == slpm_pkg::PM_DEEP && st.sensorPat
                     && st.dutyCnt < slpm_pkg::DUTY_ON;

  // ==========================================================
  // Checks
  stay_held_a: assert property (@(posedge mclk) disable iff (!arst_n)
    clkEn && !st.inReset && $past(!st.inReset) |-> $stable(st.strap))
    else $error("strap changed outside reset");
  pulls_rst_a: assert property (@(posedge mclk) disable iff (!arst_n)
    st.inReset |-> (strapPullUp | strapPullDown) == 5'h1f)
    else $error("strap pulls not on in reset");
  power_off_a: assert property (@(posedge mclk) disable iff (!arst_n)
    clkEn && !st.cenSync[1] |=> st.mode == slpm_pkg::PM_OFF)
    else $error("not off with enable low");
  radio_mode_a: assert property (@(posedge mclk) disable iff (!arst_n)
    pwr.radioOn |-> st.mode == slpm_pkg::PM_ACTIVE)
    else $error("radio on outside active");
  hiber_osc_a: assert property (@(posedge mclk) disable iff (!arst_n)
    st.mode == slpm_pkg::PM_HIBER |-> !pwr.osc8mOn && !pwr.coprocOn)
    else $error("hibernation left oscillator on");
  boot_dl_a: assert property (@(posedge mclk) disable iff (!arst_n)
    bootDownload |-> !bootFromFlash)
    else $error("both boot sources chosen");
  sleep_req_a: assert property (@(posedge mclk) disable iff (!arst_n)
    clkEn && $past(clkEn) && $changed(st.mode) && st.mode inside {slpm_pkg::PM_LIGHT,
    slpm_pkg::PM_DEEP, slpm_pkg::PM_HIBER} |-> $past(st.sleepReq) != 3'h0)
    else $error("sleep without request");
  duty_one_a: assert property (@(posedge mclk) disable iff (!arst_n)
    adcSample |-> st.dutyCnt == 7'h0)
    else $error("adc duty above one percent");
  strap_read_a: assert property (@(posedge mclk) disable iff (!arst_n)
    clkEn && addrPhase && !hwrite && haddr[7:0] == slpm_pkg::STRAP_OFS
    |=> hrdata == {27'h0, $past(st.strap)})
    else $error("strap readback wrong");
  deep_boot_a: assert property (@(posedge mclk) disable iff (!arst_n)
    clkEn && anyWake |=> pwr.fastMemCpu == ($past(st.mode) == slpm_pkg::PM_DEEP))
    else $error("fast memory grant wrong after wake");
  assoc_wake_a: assert property (@(posedge mclk) disable iff (!arst_n)
    clkEn && anyWake && st.assocEn |=> st.mode == slpm_pkg::PM_MODEM)
    else $error("association wake not to modem sleep");
  light_hold_a: assert property (@(posedge mclk) disable iff (!arst_n)
    clkEn && st.mode == slpm_pkg::PM_LIGHT && st.cenSync[1] && !sysResetReq
    && !(|(wakeVec & st.wakeEn)) |=> st.mode == slpm_pkg::PM_LIGHT)
    else $error("light sleep left without enabled wake");
  hiber_hold_a: assert property (@(posedge mclk) disable iff (!arst_n)
    clkEn && st.mode == slpm_pkg::PM_HIBER && st.cenSync[1] && !sysResetReq
    && !wakeIn.timer && !wakeIn.extInt |=> st.mode == slpm_pkg::PM_HIBER)
    else $error("hibernation left without timer or pin wake");
  clk_slow_a: assert property (@(posedge mclk) disable iff (!arst_n)
    st.mode == slpm_pkg::PM_MODEM && cpuLoad == 2'h0 |-> cpuClkSel == slpm_pkg::CLK_2M)
    else $error("modem sleep clock not slowest at no load");
  wake_cov: cover property (@(posedge mclk) st.mode == slpm_pkg::PM_LIGHT ##1
    st.mode == slpm_pkg::PM_ACTIVE);
  deep_cov: cover property (@(posedge mclk) adcSample);
  hiber_cov: cover property (@(posedge mclk) st.mode == slpm_pkg::PM_HIBER);
  latch_cov: cover property (@(posedge mclk) $fell(st.inReset));
  assoc_cov: cover property (@(posedge mclk) st.mode == slpm_pkg::PM_LIGHT ##1
    st.mode == slpm_pkg::PM_MODEM);
endmodule // slpm_core

/* test/slpm_host.sv */
// Host and resistor model for the five strap pins.
// Assumes the core drives the weak pull enables.
`timescale 1ns/1ps
module slpm_host (
  input wire logic mclk,
  input wire logic [4:0] drvEn,
  input wire logic [4:0] drvVal,
  input wire logic [4:0] pullUp,
  input wire logic [4:0] pullDn,
  output logic [4:0] pin
);
  logic [4:0] lastPin = 5'h00;
  // ==========================================================
  // Pin level: host, else pull, else a level that keeps moving
  always_comb
  begin
    for (int i = 0; i < 5; i++)
    begin
      pin[i] = drvEn[i] ? drvVal[i] : pullUp[i] ? 1'b1 : pullDn[i] ? 1'b0 : ~lastPin[i];
    end
  end
  always_ff @(posedge mclk) lastPin <= pin;
endmodule // slpm_host

/* test/tb.sv */
// Bench for the strap latch and power-mode controller.
// Assumes slpm_core and the slpm_host pin model.
`timescale 1ns/1ps
module tb;
  logic mclk = 1'b0;
  logic rstN = 1'b0;
  logic chipPowerUp = 1'b1;
  logic clkEn = 1'b1;
  logic sysResetReq = 1'b0;
  logic [4:0] drvEn = 5'h00;
  logic [4:0] drvVal = 5'h00;
  logic [4:0] strapPin, strapPullUp, strapPullDown;
  logic strapFunctional, ldoSel1v8, bootFromFlash, bootDownload, bootLogEn;
  logic slaveInRise, slaveOutRise, adcSample, hreadyout, hresp;
  slpm_pkg::slpm_wake_s wakeIn = '0;
  logic [1:0] cpuLoad = 2'h0;
  logic sensorWake = 1'b0;
  slpm_pkg::slpm_pwr_s pwr;
  slpm_pkg::slpm_clk_e cpuClkSel;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rdq;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [4:0] s = 5'h1a;
  logic [4:0] pv [6] = '{5'h00, 5'h1f, 5'h05, 5'h08, 5'h10, 5'h1a};
  logic [5:0] outv;
  int fail_count = 0, compares = 0, cycles = 0, n;
  assign outv = {ldoSel1v8, bootFromFlash, bootDownload, bootLogEn, slaveInRise, slaveOutRise};
  slpm_host host (.mclk(mclk), .drvEn(drvEn), .drvVal(drvVal), .pullUp(strapPullUp),
    .pullDn(strapPullDown), .pin(strapPin));
  slpm_core uut (.mclk(mclk), .arst_n(rstN), .clkEn(clkEn), .chipPowerUp(chipPowerUp),
    .sysResetReq(sysResetReq), .strapPin(strapPin), .strapPullUp(strapPullUp),
    .strapPullDown(strapPullDown), .strapFunctional(strapFunctional), .ldoSel1v8(ldoSel1v8),
    .bootFromFlash(bootFromFlash), .bootDownload(bootDownload), .bootLogEn(bootLogEn),
    .slaveInRise(slaveInRise), .slaveOutRise(slaveOutRise), .wakeIn(wakeIn),
    .cpuLoad(cpuLoad), .sensorWake(sensorWake), .pwr(pwr), .cpuClkSel(cpuClkSel),
    .adcSample(adcSample), .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata));
  // ==========================================================
  // Clock and hang guard
  initial forever #5 mclk = ~mclk;
  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      fail_count++;
      test_done();
    end
  end
  // ==========================================================
  // Tasks
  task automatic test_done();
    if (fail_count == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    tick(1);
    while (hreadyout !== 1'b1) tick(1);
    htrans <= 2'h0;
    hwdata <= d;
    tick(1);
    while (hreadyout !== 1'b1) tick(1);
    rdq = hrdata;
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rdq & m, e);
  endtask
  task automatic waitSt(input logic [2:0] e);
    rdq = 32'hffffffff;
    for (int i = 0; i < 40 && rdq[2:0] !== e; i++) bus(1'b0, slpm_pkg::STATE_OFS, 32'h0);
    chk(32'(rdq[2:0]), 32'(e));
  endtask
  task automatic strapChk();
    chk(32'(outv), 32'({s[0], s[1], ~s[1] & ~s[2], s[3], s[3], s[4]}));
    rdChk(slpm_pkg::STRAP_OFS, 32'h1f, 32'(s));
  endtask
  // ==========================================================
  // Main sequence
  initial
  begin
    tick(5);
    chk(32'({strapPullUp, strapPullDown, strapFunctional}), 32'h68a);
    rstN <= 1'b1;
    tick(20);
    strapChk();
    chk(32'(pwr) & 32'h280, 32'h280);
    foreach (pv[i])
    begin
      drvEn <= 5'h1f;
      drvVal <= pv[i];
      s = pv[i];
      sysResetReq <= 1'b1;
      tick(3);
      chk(32'({strapPullUp, strapPullDown, strapFunctional}), 32'h68a);
      sysResetReq <= 1'b0;
      tick(20);
      chk(32'({strapPullUp, strapPullDown, strapFunctional}), 32'h1);
      drvEn <= 5'h00;
      tick(5);
      strapChk();
    end
    bus(1'b1, slpm_pkg::STRAP_OFS, 32'h0);
    strapChk();
    rdChk(slpm_pkg::FUSE_OFS, 32'hffffffff, 32'h03000100);
    rdChk(8'h40, 32'hffffffff, 32'h0);
    rdChk(slpm_pkg::WAKE_OFS, 32'hf, 32'hf);
    bus(1'b1, slpm_pkg::WAKE_OFS, 32'hf00);
    bus(1'b1, slpm_pkg::MODE_OFS, 32'h2);
    waitSt(3'h2);
    chk(32'(pwr) & 32'h1e0, 32'h160);
    wakeIn <= 4'h4;
    tick(8);
    rdChk(slpm_pkg::STATE_OFS, 32'h7, 32'h2);
    bus(1'b1, slpm_pkg::WAKE_OFS, 32'hf);
    waitSt(3'h0);
    rdChk(slpm_pkg::STATE_OFS, 32'h8, 32'h8);
    chk(32'(pwr) & 32'h2, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      wakeIn <= 4'h0;
      bus(1'b1, slpm_pkg::MODE_OFS, 32'h2);
      waitSt(3'h2);
      wakeIn <= 4'(1 << i);
      waitSt(3'h0);
    end
    wakeIn <= 4'h0;
    bus(1'b1, slpm_pkg::MODE_OFS, 32'h43);
    waitSt(3'h3);
    chk(32'(pwr) & 32'h2e5, 32'h65);
    wakeIn <= 4'h2;
    waitSt(3'h0);
    chk(32'(pwr) & 32'h2, 32'h2);
    wakeIn <= 4'h0;
    bus(1'b1, slpm_pkg::MODE_OFS, 32'h63);
    waitSt(3'h3);
    n = 0;
    repeat (200)
    begin
      tick(1);
      n += int'(adcSample);
    end
    chk(32'(n), 32'd2);
    sensorWake <= 1'b1;
    waitSt(3'h0);
    sensorWake <= 1'b0;
    bus(1'b1, slpm_pkg::MODE_OFS, 32'h4);
    waitSt(3'h4);
    chk(32'(pwr) & 32'h2b8, 32'h0);
    wakeIn <= 4'h1;
    waitSt(3'h0);
    wakeIn <= 4'h0;
    bus(1'b1, slpm_pkg::MODE_OFS, 32'h12);
    waitSt(3'h2);
    wakeIn <= 4'h8;
    tick(3);
    wakeIn <= 4'h0;
    waitSt(3'h1);
    chk(32'(pwr) & 32'h280, 32'h200);
    for (int l = 0; l < 4; l++)
    begin
      cpuLoad <= 2'(l);
      tick(4);
      chk(32'(cpuClkSel), 32'(l >= 2 ? 0 : 2 - l));
    end
    clkEn <= 1'b0;
    chipPowerUp <= 1'b0;
    tick(10);
    chk(32'(pwr) & 32'h280, 32'h200);
    clkEn <= 1'b1;
    waitSt(3'h5);
    chk(32'(pwr) & 32'h280, 32'h0);
    rstN <= 1'b0;
    chipPowerUp <= 1'b1;
    drvEn <= 5'h1f;
    drvVal <= 5'h05;
    s = 5'h05;
    tick(5);
    chk(32'({strapPullUp, strapPullDown, strapFunctional}), 32'h68a);
    rstN <= 1'b1;
    tick(20);
    drvEn <= 5'h00;
    strapChk();
    waitSt(3'h0);
    test_done();
  end
endmodule // tb
